// ### rtl/mcs_modem_ctrl.sv
// module: modem control latches and lead change reporting
module mcs_modem_ctrl
   import mcs_pkg::*;
#(
   parameter int unsigned CHANNELS = MCS_CHANNELS,
   parameter int unsigned RING_CYC = MCS_RING_STABLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // modem latch strobe from the control sequencer
   input wire logic latch_strobe,
   input wire logic [mcs_pkg::MCS_CHAN_W-1:0] latch_chan,
   input wire logic latch_rts,
   input wire logic latch_dtr,
   // per-channel line control registers, flattened
   input wire logic [CHANNELS*mcs_pkg::MCS_LCR_W-1:0] line_control_reg,
   // data path from and to the uarts
   input wire logic [CHANNELS-1:0] uart_txd,
   output logic [CHANNELS-1:0] uart_rxd,
   // modem leads
   output logic [CHANNELS-1:0] modem_txd,
   output logic [CHANNELS-1:0] modem_rts,
   output logic [CHANNELS-1:0] modem_dtr,
   input wire logic [CHANNELS-1:0] modem_rxd,
   input wire logic [CHANNELS-1:0] modem_cts,
   input wire logic [CHANNELS-1:0] modem_dsr,
   input wire logic [CHANNELS-1:0] modem_dcd,
   input wire logic [CHANNELS-1:0] modem_ring,
   // status register view, four bits per channel
   output logic [CHANNELS*mcs_pkg::MCS_ST_W-1:0] status_reg,
   // entry toward the shared receive fifo
   output logic fifo_valid,
   input wire logic fifo_ready,
   output logic [mcs_pkg::MCS_CHAN_W-1:0] fifo_chan,
   output logic [mcs_pkg::MCS_ST_W-1:0] fifo_status
);
   logic [CHANNELS-1:0] ring_flt;
   logic [CHANNELS-1:0] rts_reg, rts_next, dtr_reg, dtr_next;
   logic [CHANNELS-1:0] txd_reg, rxd_reg;
   logic [CHANNELS*MCS_ST_W-1:0] st_reg, st_next;
   logic [CHANNELS-1:0] pend_reg, pend_next;
   mcs_scan_t scan_reg, scan_next;
   logic [MCS_CHAN_W-1:0] ptr_reg, ptr_next;
   logic fv_reg, fv_next;
   logic [MCS_CHAN_W-1:0] fc_reg, fc_next;
   logic [MCS_ST_W-1:0] fs_reg, fs_next;

   // ----------------------------------------
   // ring filters
   // ----------------------------------------
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ring
      mcs_ring_filter #(.STABLE_CYC(RING_CYC)) u_ring (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .ring_raw(modem_ring[g]),
         .ring_stable(ring_flt[g])
      );
   end

   function automatic logic [MCS_ST_W-1:0] lead_word(input int unsigned c);
      logic [MCS_ST_W-1:0] w;
      w = MCS_ST_RESET;
      w[MCS_ST_CTS] = modem_cts[c];
      w[MCS_ST_DSR] = modem_dsr[c];
      w[MCS_ST_DCD] = modem_dcd[c];
      w[MCS_ST_RING] = ring_flt[c];
      return w;
   endfunction : lead_word

   // ----------------------------------------
   // latches, status, change scan
   // ----------------------------------------
   always_comb begin
      rts_next = rts_reg;
      dtr_next = dtr_reg;
      st_next = st_reg;
      pend_next = pend_reg;
      scan_next = scan_reg;
      ptr_next = ptr_reg;
      fv_next = fv_reg;
      fc_next = fc_reg;
      fs_next = fs_reg;
      if (latch_strobe) begin
         rts_next[latch_chan] = latch_rts;
         dtr_next[latch_chan] = latch_dtr;
      end
      if (fv_reg && fifo_ready) begin
         fv_next = 1'b0;
      end
      case (scan_reg)
         MCS_SCAN_IDLE: begin
            if (pend_reg[ptr_reg] && !fv_reg) begin
               scan_next = MCS_SCAN_POST;
            end else begin
               ptr_next = ptr_reg + MCS_CHAN_W'(1);
            end
         end
         MCS_SCAN_POST: begin
            pend_next[ptr_reg] = 1'b0;
            fv_next = 1'b1;
            fc_next = ptr_reg;
            fs_next = st_reg[ptr_reg*MCS_ST_W +: MCS_ST_W];
            ptr_next = ptr_reg + MCS_CHAN_W'(1);
            scan_next = MCS_SCAN_IDLE;
         end
         default: scan_next = MCS_SCAN_IDLE;
      endcase
      for (int unsigned c = 0; c < CHANNELS; c++) begin
         if (lead_word(c) != st_reg[c*MCS_ST_W +: MCS_ST_W]) begin
            st_next[c*MCS_ST_W +: MCS_ST_W] = lead_word(c);
            if (line_control_reg[c*MCS_LCR_W + MCS_LCR_REPORT_BIT]) begin
               pend_next[c] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rts_reg <= '0;
         dtr_reg <= '0;
         txd_reg <= '1;
         rxd_reg <= '1;
         st_reg <= '0;
         pend_reg <= '0;
         scan_reg <= MCS_SCAN_IDLE;
         ptr_reg <= '0;
         fv_reg <= 1'b0;
         fc_reg <= '0;
         fs_reg <= MCS_ST_RESET;
      end else begin
         rts_reg <= rts_next;
         dtr_reg <= dtr_next;
         txd_reg <= uart_txd;
         rxd_reg <= modem_rxd;
         st_reg <= st_next;
         pend_reg <= pend_next;
         scan_reg <= scan_next;
         ptr_reg <= ptr_next;
         fv_reg <= fv_next;
         fc_reg <= fc_next;
         fs_reg <= fs_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign modem_txd = txd_reg;
   assign modem_rts = rts_reg;
   assign modem_dtr = dtr_reg;
   assign uart_rxd = rxd_reg;
   assign status_reg = st_reg;
   assign fifo_valid = fv_reg;
   assign fifo_chan = fc_reg;
   assign fifo_status = fs_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_latch_both: assert property (@(posedge sys_clk) disable iff (!reset_n)
      latch_strobe |=> modem_rts[$past(latch_chan)] == $past(latch_rts)
         && modem_dtr[$past(latch_chan)] == $past(latch_dtr))
      else $error("modem latch did not take both levels");
   chk_tx_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 modem_txd == $past(uart_txd))
      else $error("transmit data gated");
   chk_rx_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 uart_rxd == $past(modem_rxd))
      else $error("receive data gated");
   chk_status_cts: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 status_reg[MCS_ST_CTS] == $past(modem_cts[0]))
      else $error("status not following clear-to-send");

   // status lanes, every channel
   for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
      chk_status_leads: assert property (@(posedge sys_clk) disable iff (!reset_n)
         ##1 status_reg[g*MCS_ST_W +: MCS_ST_W] == {$past(ring_flt[g]), $past(modem_dcd[g]),
            $past(modem_dsr[g]), $past(modem_cts[g])})
         else $error("status nibble not following leads");
   end

   chk_fifo_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_chan)
         && $stable(fifo_status))
      else $error("fifo entry dropped under back-pressure");
   chk_entry_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
      fifo_valid && fifo_ready |=> !fifo_valid)
      else $error("entry offered twice");
   chk_scan_post: assert property (@(posedge sys_clk) disable iff (!reset_n)
      scan_reg == MCS_SCAN_POST |=> fifo_valid)
      else $error("scan post did not offer an entry");
   chk_entry_nibble: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(fifo_valid) |-> fifo_status == MCS_ST_W'($past(status_reg) >> (fifo_chan * MCS_ST_W)))
      else $error("entry status differs from the channel nibble");

   chk_post_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(fifo_valid) |-> line_control_reg[fifo_chan*MCS_LCR_W + MCS_LCR_REPORT_BIT]
         || $past(line_control_reg[fifo_chan*MCS_LCR_W + MCS_LCR_REPORT_BIT], 2))
      else $error("entry posted for a channel with reporting off");
   chk_change_post: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(modem_dcd[0]) && line_control_reg[MCS_LCR_REPORT_BIT] && fifo_ready
         |-> ##[1:40] fifo_valid && fifo_chan == '0)
      else $error("carrier change not posted");
   chk_rts_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !latch_strobe |=> $stable(modem_rts) && $stable(modem_dtr))
      else $error("modem latch moved without strobe");
endmodule : mcs_modem_ctrl

// ### rtl/mcs_pkg.sv
// package: constants and types for the modem control and status block
package mcs_pkg;
   localparam int unsigned MCS_CLK_HZ = 200_000_000;
   localparam int unsigned MCS_RING_STABLE_MS = 30;
   // least time rounds down, the integer division truncates
   localparam int unsigned MCS_RING_STABLE_CYC =
      (MCS_CLK_HZ / 1000) * MCS_RING_STABLE_MS;
   localparam int unsigned MCS_CHANNELS = 8;
   localparam int unsigned MCS_CHAN_W = 3;
   localparam int unsigned MCS_FIFO_DEPTH = 256;
   localparam int unsigned MCS_LCR_W = 16;
   localparam int unsigned MCS_LCR_REPORT_BIT = 8;
   // status nibble positions
   localparam int unsigned MCS_ST_CTS = 0;
   localparam int unsigned MCS_ST_DSR = 1;
   localparam int unsigned MCS_ST_DCD = 2;
   localparam int unsigned MCS_ST_RING = 3;
   localparam int unsigned MCS_ST_W = 4;
   localparam logic [MCS_ST_W-1:0] MCS_ST_RESET = 4'h0;
   typedef enum logic [1:0] {
      MCS_SCAN_IDLE = 2'b00,
      MCS_SCAN_POST = 2'b01
   } mcs_scan_t;
endpackage : mcs_pkg

// ### rtl/mcs_ring_filter.sv
// module: per-channel ring indicator stability filter
module mcs_ring_filter
   import mcs_pkg::*;
#(
   parameter int unsigned STABLE_CYC = MCS_RING_STABLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // raw and filtered ring
   input wire logic ring_raw,
   output logic ring_stable
);
   localparam int unsigned CW = $clog2(STABLE_CYC + 1);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic last_reg;
   logic last_next;
   logic stable_reg;
   logic stable_next;

   always_comb begin
      last_next = ring_raw;
      cnt_next = cnt_reg;
      stable_next = stable_reg;
      if (ring_raw != last_reg) begin
         cnt_next = '0;
      end else if (ring_raw != stable_reg) begin
         if (cnt_reg == CW'(STABLE_CYC - 1)) begin
            stable_next = ring_raw;
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + CW'(1);
         end
      end else begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= '0;
         last_reg <= 1'b0;
         stable_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         last_reg <= last_next;
         stable_reg <= stable_next;
      end
   end

   assign ring_stable = stable_reg;

   chk_ring_no_glitch: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(stable_reg) |-> $past(ring_raw) == stable_reg)
      else $error("ring output changed without stable input");
endmodule : mcs_ring_filter

// ### test/mcs_modem_ctrl_tb.sv
// testbench for the modem control and status block
module mcs_modem_ctrl_tb import mcs_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned RC = 20;
   // scaled hold of terminal-ready after a lost call
   localparam int unsigned HOLD_CYC = 40;
   logic sys_clk, reset_n, latch_strobe, latch_rts, latch_dtr, fifo_ready, fifo_valid;
   logic [2:0] latch_chan, fifo_chan;
   logic [127:0] line_control_reg;
   logic [7:0] uart_txd, uart_rxd, modem_txd, modem_rts, modem_dtr, modem_rxd;
   logic [7:0] modem_cts, modem_dsr, modem_dcd, modem_ring, want_cts, want_dsr, want_dcd, want_ring;
   logic [31:0] status_reg;
   logic [3:0] fifo_status;
   int failures, tests_run, posts;
   mcs_modem_ctrl #(.CHANNELS(8), .RING_CYC(RC)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
      .latch_strobe(latch_strobe), .latch_chan(latch_chan), .latch_rts(latch_rts),
      .latch_dtr(latch_dtr), .line_control_reg(line_control_reg), .uart_txd(uart_txd),
      .uart_rxd(uart_rxd), .modem_txd(modem_txd), .modem_rts(modem_rts), .modem_dtr(modem_dtr),
      .modem_rxd(modem_rxd), .modem_cts(modem_cts), .modem_dsr(modem_dsr),
      .modem_dcd(modem_dcd), .modem_ring(modem_ring), .status_reg(status_reg),
      .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_chan(fifo_chan),
      .fifo_status(fifo_status));
   mcs_modem_model modem (.sys_clk(sys_clk), .reset_n(reset_n), .want_cts(want_cts),
      .want_dsr(want_dsr), .want_dcd(want_dcd), .want_ring(want_ring), .modem_txd(modem_txd),
      .modem_rxd(modem_rxd), .modem_cts(modem_cts), .modem_dsr(modem_dsr),
      .modem_dcd(modem_dcd), .modem_ring(modem_ring));
   // -----------------------------------------
   // helpers
   // -----------------------------------------
   // handshake counted mid-cycle, away from the launching edge
   always @(negedge sys_clk) if (fifo_valid === 1'b1 && fifo_ready === 1'b1) posts++;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic get_entry(output logic [2:0] ch, output logic [3:0] st);
      int n;
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (fifo_valid !== 1'b1 && n < 40);
      if (fifo_valid !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      ch = fifo_chan;
      st = fifo_status;
   endtask : get_entry
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_latch;
      @(posedge sys_clk);
      {latch_strobe, latch_chan, latch_rts, latch_dtr} <= {1'b1, 3'h5, 1'b1, 1'b0};
      @(posedge sys_clk);
      {latch_chan, latch_rts, latch_dtr} <= {3'h6, 1'b0, 1'b1};
      @(posedge sys_clk);
      latch_strobe <= 1'b0;
      cyc(2);
      chk("rts", modem_rts, 8'h20);
      chk("dtr", modem_dtr, 8'h40);
   endtask : t_latch
   task automatic t_data;
      @(posedge sys_clk);
      uart_txd <= 8'ha5;
      cyc(4);
      chk("txd", modem_txd, 8'ha5);
      chk("rxd", uart_rxd, 8'ha5);
   endtask : t_data
   task automatic t_fifo;
      int n, p;
      @(posedge sys_clk);
      line_control_reg[2*16+8] <= 1'b1;
      fifo_ready <= 1'b0;
      want_dsr[2] <= 1'b1;
      cyc(4);
      chk("st2", status_reg[11:8], 4'h2);
      n = 0;
      while (fifo_valid !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      if (fifo_valid !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      cyc(3);
      chk("fvalid", fifo_valid, 1'b1);
      chk("fchan", fifo_chan, 3'h2);
      chk("fstat", fifo_status, 4'h2);
      @(posedge sys_clk);
      fifo_ready <= 1'b1;
      cyc(2);
      chk("fdone", fifo_valid, 1'b0);
      p = posts;
      @(posedge sys_clk);
      want_dcd[3] <= 1'b1;
      cyc(40);
      chk("st3", status_reg[15:12], 4'h4);
      chk("noentry", posts, p);
   endtask : t_fifo
   task automatic t_ring;
      int p;
      p = posts;
      @(posedge sys_clk);
      line_control_reg[4*16+8] <= 1'b1;
      want_ring[4] <= 1'b1;
      cyc(RC / 2);
      @(posedge sys_clk);
      want_ring[4] <= 1'b0;
      cyc(RC + 10);
      chk("ringshort", status_reg[19:16], 4'h0);
      chk("ringquiet", posts, p);
      @(posedge sys_clk);
      want_ring[4] <= 1'b1;
      cyc(RC);
      chk("ringearly", status_reg[19:16], 4'h0);
      cyc(4);
      chk("ringlong", status_reg[19:16], 4'h8);
      cyc(30);
      chk("ringpost", posts, p + 1);
   endtask : t_ring
   task automatic t_call;
      logic [2:0] ch;
      logic [3:0] st;
      @(posedge sys_clk);
      {latch_strobe, latch_chan, latch_rts, latch_dtr} <= {1'b1, 3'h0, 1'b1, 1'b1};
      line_control_reg[8] <= 1'b1;
      @(posedge sys_clk);
      latch_strobe <= 1'b0;
      // no ring from this modem: data-set-ready comes first
      want_dsr[0] <= 1'b1;
      get_entry(ch, st);
      chk("firstch", ch, 3'h0);
      chk("firstst", st, 4'h2);
      // carrier must arrive inside the wait bound of get_entry
      @(posedge sys_clk);
      {want_cts[0], want_dcd[0]} <= 2'b11;
      get_entry(ch, st);
      chk("carrst", st, 4'h7);
      @(posedge sys_clk);
      want_dcd[0] <= 1'b0;
      get_entry(ch, st);
      chk("lossst", st, 4'h3);
      chk("st0", status_reg[3:0], 4'h3);
      // host drops terminal-ready at once and holds it down
      @(posedge sys_clk);
      {latch_strobe, latch_dtr} <= 2'b10;
      @(posedge sys_clk);
      latch_strobe <= 1'b0;
      cyc(HOLD_CYC);
      chk("dtrheld", modem_dtr[0], 1'b0);
      @(posedge sys_clk);
      {latch_strobe, latch_dtr} <= 2'b11;
      @(posedge sys_clk);
      latch_strobe <= 1'b0;
      cyc(2);
      chk("dtrup", modem_dtr[0], 1'b1);
      chk("rtskept", modem_rts[0], 1'b1);
   endtask : t_call
   // -----------------------------------------
   // clock, reset, sequence
   // -----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      report_and_stop();
   end
   initial begin
      {reset_n, latch_strobe, latch_chan, latch_rts, latch_dtr, fifo_ready} = 8'h0;
      line_control_reg = 128'h0;
      {uart_txd, want_cts, want_dsr, want_dcd, want_ring} = 40'hff00000000;
      failures = 0;
      tests_run = 0;
      posts = 0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_latch();
      t_data();
      t_fifo();
      t_ring();
      t_call();
      report_and_stop();
   end
endmodule : mcs_modem_ctrl_tb

// ### test/mcs_modem_model.sv
// modem partner: drives status leads and loops transmit data back
module mcs_modem_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // lead levels asked for by the bench
   input wire logic [7:0] want_cts,
   input wire logic [7:0] want_dsr,
   input wire logic [7:0] want_dcd,
   input wire logic [7:0] want_ring,
   // leads to and from the device
   input wire logic [7:0] modem_txd,
   output logic [7:0] modem_rxd,
   output logic [7:0] modem_cts,
   output logic [7:0] modem_dsr,
   output logic [7:0] modem_dcd,
   output logic [7:0] modem_ring
);
   timeunit 1ns;
   timeprecision 100ps;
   // remote end echoes the line, one cycle late
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         modem_rxd <= 8'hff;
         {modem_cts, modem_dsr, modem_dcd, modem_ring} <= 32'h0;
      end else begin
         modem_rxd <= modem_txd;
         {modem_cts, modem_dsr, modem_dcd, modem_ring} <= {want_cts, want_dsr, want_dcd, want_ring};
      end
   end
endmodule : mcs_modem_model
